/* File: rtl/csa_pkg.sv */
// Shared constants for the conversion slot arbiter: register indices,
// field positions, reset values and the sequencing states.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package csa_pkg;

  localparam int          NUM_SLOTS       = 16;
  localparam int          SLOT_W          = 4;
  localparam int          PTR_W           = 5;

  // Round-robin pointer codes
  localparam logic [4:0]  PTR_NONE        = 5'h10;
  localparam logic [4:0]  PTR_LAST_SLOT   = 5'h0F;

  // Cutoff codes
  localparam logic [4:0]  CUTOFF_RESET    = 5'h00;
  localparam logic [4:0]  CUTOFF_ALL_HP   = 5'h10;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CONTROL     = 8'h00;
  localparam logic [7:0]  IDX_PENDING     = 8'h01;
  localparam logic [7:0]  IDX_OVERRUN     = 8'h02;
  localparam logic [7:0]  IDX_STATUS      = 8'h03;
  localparam logic [7:0]  IDX_PRI_CTL     = 8'h09;
  localparam logic [7:0]  IDX_FORCE       = 8'h0D;

  // Field positions
  localparam int          CTL_SRST_BIT    = 0;
  localparam int          PRI_CUTOFF_LSB  = 0;
  localparam int          PRI_PTR_LSB     = 5;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_SLOT_LSB   = 4;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  localparam logic [15:0] FLAGS_RESET     = 16'h0000;

  // Conversion sequencing, Gray along idle -> busy -> idle
  typedef enum logic [1:0] {
    CSA_IDLE = 2'b00,
    CSA_BUSY = 2'b01
  } csa_state_e;

endpackage

/* File: rtl/csa_arbiter.sv */
// Combinational slot selection: fixed-priority group below the cutoff,
// round-robin group from the cutoff upward.
// Assumes pending flags, cutoff and pointer come from registers on aclk.
`timescale 1ns/100ps

module csa_arbiter #(
  parameter int NUM_SLOTS = 16
) (
  input  wire logic [NUM_SLOTS-1:0] pending,
  input  wire logic [4:0]           cutoff,
  input  wire logic [4:0]           rr_pointer,
  output logic                      grant_valid,
  output logic [3:0]                grant_slot,
  output logic                      grant_is_rr
);

  initial begin
    if (NUM_SLOTS != 16) begin
      $error("csa_arbiter serves exactly sixteen slots");
    end
  end

  // Values above the all-high code are illegal; treat them as all-high
  function automatic logic [4:0] clip_cutoff(input logic [4:0] c);
    clip_cutoff = (c > csa_pkg::CUTOFF_ALL_HP) ? csa_pkg::CUTOFF_ALL_HP : c;
  endfunction

  // Slot after the pointer; 0Fh and the no-slot code both restart at 0
  function automatic logic [3:0] rr_start(input logic [4:0] p);
    rr_start = (p >= csa_pkg::PTR_LAST_SLOT) ? 4'h0 : 4'(p + 5'h01);
  endfunction

  logic [4:0]           cut;
  logic [NUM_SLOTS-1:0] hp_req;
  logic [NUM_SLOTS-1:0] rr_req;
  logic [3:0]           start;
  logic [3:0]           idx;
  logic                 hp_found;
  logic                 rr_found;
  logic [3:0]           hp_slot;
  logic [3:0]           rr_slot;

  always_comb begin
    cut      = clip_cutoff(cutoff);
    start    = rr_start(rr_pointer);
    hp_found = 1'b0;
    rr_found = 1'b0;
    hp_slot  = 4'h0;
    rr_slot  = 4'h0;
    idx      = 4'h0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      hp_req[i] = pending[i] && (5'(i) < cut);
      rr_req[i] = pending[i] && (5'(i) >= cut);
    end
    // Lowest-numbered high-priority slot first
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (hp_req[i]) begin
        hp_found = 1'b1;
        hp_slot  = 4'(i);
      end
    end
    // Upward search from the slot after the pointer, wrapping at 15
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      idx = 4'(start + 4'(i));
      if (rr_req[idx]) begin
        rr_found = 1'b1;
        rr_slot  = idx;
      end
    end
    grant_valid = hp_found || rr_found;
    grant_is_rr = !hp_found && rr_found;
    grant_slot  = hp_found ? hp_slot : rr_slot;
  end

endmodule

/* File: rtl/csa_top.sv */
// Conversion slot arbiter with AXI4-Lite register access.
// Assumes slot triggers and conversion-done arrive from logic on aclk,
// and that the converter asserts conv_done once per started conversion.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps

module csa_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Converter side
  input  wire logic [15:0]       slot_trigger,
  input  wire logic              conv_done,
  output logic                   conv_start,
  output logic [3:0]             conv_slot,
  output logic                   conv_busy
);

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("csa_top needs an address width from 8 to 32");
    end
  end

  // Word index of a byte address; low two bits ignored
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    logic [31:0] wide;
    wide       = 32'(a);
    word_index = wide[9:2];
  endfunction

  function automatic logic upper_zero(input logic [ADDR_W-1:0] a);
    upper_zero = (ADDR_W <= 10) ? 1'b1 : ((a >> 10) == '0);
  endfunction

  // Bus state
  logic              aw_hold;
  logic              w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              next_aw_hold;
  logic              next_w_hold;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;

  // Core state
  logic [15:0]         slot_pending_flags;
  logic [15:0]         slot_overrun_flags;
  logic [4:0]          priority_cutoff;
  logic [4:0]          active_cutoff;
  logic [4:0]          last_rr_slot_pointer;
  logic                pri_update_pending;
  csa_pkg::csa_state_e state;
  logic [15:0]         next_pending;
  logic [15:0]         next_overrun;
  logic [4:0]          next_cutoff;
  logic [4:0]          next_active_cutoff;
  logic [4:0]          next_pointer;
  logic                next_pri_update;
  csa_pkg::csa_state_e next_state;
  logic                next_conv_start;
  logic [3:0]          next_conv_slot;
  logic                next_conv_busy;

  // Decoded write effects
  logic        wr_go;
  logic [7:0]  wr_idx;
  logic        wr_mapped;
  logic        module_soft_reset;
  logic        pri_write;
  logic [15:0] force_set;
  logic [15:0] overrun_clr;
  logic [7:0]  rd_idx;

  // Arbitration
  logic        grant_valid;
  logic [3:0]  grant_slot;
  logic        grant_is_rr;
  logic        start;
  logic [15:0] hw_clear;
  logic [15:0] overrun_set;

  csa_arbiter #(
    .NUM_SLOTS (csa_pkg::NUM_SLOTS)
  ) u_arbiter (
    .pending     (slot_pending_flags),
    .cutoff      (active_cutoff),
    .rr_pointer  (last_rr_slot_pointer),
    .grant_valid (grant_valid),
    .grant_slot  (grant_slot),
    .grant_is_rr (grant_is_rr)
  );

  // Write path: address and data taken in either order, executed together
  always_comb begin
    wr_go        = aw_hold && w_hold && !s_axi_bvalid;
    wr_idx       = word_index(aw_addr);
    wr_mapped    = upper_zero(aw_addr) &&
                   (wr_idx == csa_pkg::IDX_CONTROL || wr_idx == csa_pkg::IDX_PENDING ||
                    wr_idx == csa_pkg::IDX_OVERRUN || wr_idx == csa_pkg::IDX_STATUS ||
                    wr_idx == csa_pkg::IDX_PRI_CTL || wr_idx == csa_pkg::IDX_FORCE);
    next_aw_hold = (aw_hold && !wr_go) || (s_axi_awvalid && s_axi_awready);
    next_w_hold  = (w_hold && !wr_go) || (s_axi_wvalid && s_axi_wready);
    next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    next_bvalid  = (s_axi_bvalid && !s_axi_bready) || wr_go;
    next_bresp   = wr_go ? (wr_mapped ? csa_pkg::RESP_OKAY : csa_pkg::RESP_SLVERR)
                         : s_axi_bresp;
    // No new address or data until the response has been taken
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready  = !next_w_hold && !next_bvalid;

    module_soft_reset = wr_go && upper_zero(aw_addr) && wr_idx == csa_pkg::IDX_CONTROL &&
                        w_strb[0] && w_data[csa_pkg::CTL_SRST_BIT];
    // Any write to the priority register counts, whatever the lanes
    pri_write = wr_go && upper_zero(aw_addr) && wr_idx == csa_pkg::IDX_PRI_CTL;
    force_set = '0;
    overrun_clr = '0;
    if (wr_go && upper_zero(aw_addr) && wr_idx == csa_pkg::IDX_FORCE) begin
      force_set = {w_strb[1] ? w_data[15:8] : 8'h00,
                   w_strb[0] ? w_data[7:0] : 8'h00};
    end
    if (wr_go && upper_zero(aw_addr) && wr_idx == csa_pkg::IDX_OVERRUN) begin
      overrun_clr = {w_strb[1] ? w_data[15:8] : 8'h00,
                     w_strb[0] ? w_data[7:0] : 8'h00};
    end
  end

  // Read path: one read at a time, data captured when the address is taken
  always_comb begin
    rd_idx       = word_index(s_axi_araddr);
    next_rvalid  = (s_axi_rvalid && !s_axi_rready) || (s_axi_arvalid && s_axi_arready);
    next_arready = !next_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rdata = 32'h0000_0000;
      next_rresp = csa_pkg::RESP_OKAY;
      if (!upper_zero(s_axi_araddr)) begin
        next_rresp = csa_pkg::RESP_SLVERR;
      end else begin
        unique case (rd_idx)
          csa_pkg::IDX_CONTROL: next_rdata = 32'h0000_0000;
          csa_pkg::IDX_PENDING: next_rdata = {16'h0000, slot_pending_flags};
          csa_pkg::IDX_OVERRUN: next_rdata = {16'h0000, slot_overrun_flags};
          csa_pkg::IDX_STATUS: begin
            next_rdata[csa_pkg::STAT_BUSY_BIT]               = conv_busy;
            next_rdata[csa_pkg::STAT_SLOT_LSB +: 4]          = conv_slot;
          end
          csa_pkg::IDX_PRI_CTL: begin
            next_rdata[csa_pkg::PRI_CUTOFF_LSB +: 5] = priority_cutoff;
            next_rdata[csa_pkg::PRI_PTR_LSB +: 5]    = last_rr_slot_pointer;
          end
          csa_pkg::IDX_FORCE: next_rdata = 32'h0000_0000;
          default: next_rresp = csa_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  // Arbitration, pending and overrun flags, pointer and sequencing
  always_comb begin
    // Grants wait while a priority update is queued
    start       = (state == csa_pkg::CSA_IDLE) && grant_valid && !pri_update_pending;
    hw_clear    = start ? (16'h0001 << grant_slot) : 16'h0000;
    // A trigger on an already pending, not-now-cleared flag is an overrun;
    // forces never touch overrun
    overrun_set = slot_trigger & slot_pending_flags & ~hw_clear;
    // Sets win over the grant's clear
    next_pending = (slot_pending_flags & ~hw_clear) | slot_trigger | force_set;
    next_overrun = (slot_overrun_flags & ~overrun_clr) | overrun_set;

    next_cutoff = priority_cutoff;
    if (pri_write && w_strb[0]) begin
      next_cutoff = w_data[csa_pkg::PRI_CUTOFF_LSB +: 5];
    end
    next_pri_update    = pri_update_pending || pri_write;
    next_active_cutoff = active_cutoff;
    next_pointer       = last_rr_slot_pointer;
    if (start && grant_is_rr) begin
      next_pointer = 5'(grant_slot);
    end
    // Queued update lands only when no conversion is running
    if (pri_update_pending && state == csa_pkg::CSA_IDLE) begin
      next_active_cutoff = priority_cutoff;
      next_pointer       = csa_pkg::PTR_NONE;
      next_pri_update    = pri_write;
    end

    next_state      = state;
    next_conv_start = 1'b0;
    next_conv_slot  = conv_slot;
    unique case (state)
      csa_pkg::CSA_IDLE: begin
        if (start) begin
          next_state      = csa_pkg::CSA_BUSY;
          next_conv_start = 1'b1;
          next_conv_slot  = grant_slot;
        end
      end
      csa_pkg::CSA_BUSY: begin
        if (conv_done) begin
          next_state = csa_pkg::CSA_IDLE;
        end
      end
    endcase
    next_conv_busy = (next_state == csa_pkg::CSA_BUSY);

    // Soft reset clears the arbitration state but not the bus
    if (module_soft_reset) begin
      next_pending       = csa_pkg::FLAGS_RESET;
      next_overrun       = csa_pkg::FLAGS_RESET;
      next_cutoff        = csa_pkg::CUTOFF_RESET;
      next_active_cutoff = csa_pkg::CUTOFF_RESET;
      next_pointer       = csa_pkg::PTR_NONE;
      next_pri_update    = 1'b0;
      next_state         = csa_pkg::CSA_IDLE;
      next_conv_start    = 1'b0;
      next_conv_slot     = 4'h0;
      next_conv_busy     = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= csa_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= csa_pkg::RESP_OKAY;
    end else begin
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_pending_flags   <= csa_pkg::FLAGS_RESET;
      slot_overrun_flags   <= csa_pkg::FLAGS_RESET;
      priority_cutoff      <= csa_pkg::CUTOFF_RESET;
      active_cutoff        <= csa_pkg::CUTOFF_RESET;
      last_rr_slot_pointer <= csa_pkg::PTR_NONE;
      pri_update_pending   <= 1'b0;
      state                <= csa_pkg::CSA_IDLE;
      conv_start           <= 1'b0;
      conv_slot            <= 4'h0;
      conv_busy            <= 1'b0;
    end else begin
      slot_pending_flags   <= next_pending;
      slot_overrun_flags   <= next_overrun;
      priority_cutoff      <= next_cutoff;
      active_cutoff        <= next_active_cutoff;
      last_rr_slot_pointer <= next_pointer;
      pri_update_pending   <= next_pri_update;
      state                <= next_state;
      conv_start           <= next_conv_start;
      conv_slot            <= next_conv_slot;
      conv_busy            <= next_conv_busy;
    end
  end

endmodule

/* File: tb/csa_top_chk.sv */
// Concurrent checks on the arbiter's register bus and converter ports.
// Assumes it is bound into csa_top and sees only that module's ports.
`timescale 1ns/100ps

module csa_top_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              conv_done,
  input wire logic              conv_start,
  input wire logic              conv_busy
);
  logic rd_frc;
  logic next_rd_frc;

  // Remembers that the read in flight targets the force register
  always_comb begin
    next_rd_frc = rd_frc;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rd_frc = (s_axi_araddr == ADDR_W'({csa_pkg::IDX_FORCE, 2'b00}));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_frc <= 1'b0;
    end else begin
      rd_frc <= next_rd_frc;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_start_pulse; conv_start |=> !conv_start; endproperty
  property p_start_busy; conv_start |-> conv_busy; endproperty
  property p_done_idle; conv_busy && conv_done |=> !conv_busy; endproperty
  property p_busy_rise; $rose(conv_busy) |-> conv_start; endproperty
  property p_no_overlap; conv_start |-> !$past(conv_busy); endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  property p_force_rd0; s_axi_rvalid && rd_frc |-> s_axi_rdata == 32'h00000000; endproperty

  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  a_done_idle: assert property (p_done_idle) else $error("busy after done");
  a_busy_rise: assert property (p_busy_rise) else $error("busy without start");
  a_no_overlap: assert property (p_no_overlap) else $error("start while busy");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_lat: assert property (p_r_lat) else $error("late read answer");
  a_b_lat: assert property (p_b_lat) else $error("late write answer");
  a_force_rd0: assert property (p_force_rd0) else $error("force reads nonzero");

  c_start: cover property (conv_start);
  c_done: cover property (conv_busy && conv_done);
  c_force_rd: cover property (s_axi_rvalid && rd_frc);
endmodule

bind csa_top csa_top_chk #(.ADDR_W(ADDR_W)) u_csa_top_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .conv_done(conv_done), .conv_start(conv_start),
  .conv_busy(conv_busy)
);

/* File: tb/csa_top_test.sv */
// Self-checking bench: AXI4-Lite master, converter stand-in, arbitration model.
// Assumes csa_top with 8-bit addresses; slot triggers come from the bench.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module csa_top_test;
  localparam logic [7:0] A_PRI = csa_pkg::IDX_PRI_CTL << 2;
  localparam logic [7:0] A_FRC = csa_pkg::IDX_FORCE << 2;
  localparam logic [7:0] A_PND = csa_pkg::IDX_PENDING << 2;
  localparam logic [7:0] A_OVF = csa_pkg::IDX_OVERRUN << 2;
  logic        aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic        done, start, busy;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  slot;
  logic [15:0] pend_m, m, trg;
  int          err_total, num_checks, cut_m, ptr_m, cyc, seed;
  bit          busy_open, hit;

  csa_top u_csa_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .slot_trigger(trg), .conv_done(done), .conv_start(start),
    .conv_slot(slot), .conv_busy(busy)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Bound on the whole run; roughly twenty times the expected length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      close_out;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    // Optional done pulse so a grant meets this write's execute cycle
    done <= hit;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
      done <= 1'b0;
    end while (bv !== 1'b1);
    r = bresp;
    br <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd; r = rresp;
    rr <= 1'b0;
  endtask

  // Reference arbitration: fixed group first, then round robin after pointer
  function automatic int pick(logic [15:0] p, int cut, int ptr);
    int s, cf, st;
    cf = (cut > 16) ? 16 : cut;
    st = (ptr >= 15) ? 0 : ptr + 1;
    for (int i = 0; i < cf; i++) if (p[i]) return i;
    for (int j = 0; j < 16; j++) begin
      s = (st + j) % 16;
      if (s >= cf && p[s]) return s;
    end
    return -1;
  endfunction

  // Converts every pending slot, leaving the last conversion running
  task automatic drain;
    int g, n;
    while (pend_m != 16'h0000) begin
      if (busy_open) begin
        @(posedge aclk) done <= 1'b1;
        @(posedge aclk) done <= 1'b0;
      end
      g = pick(pend_m, cut_m, ptr_m);
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (start !== 1'b1 && n < 60);
      `CHK(start, 1'b1)
      `CHK(slot, 4'(g))
      pend_m[g] = 1'b0;
      if (g >= cut_m) ptr_m = g;
      busy_open = 1'b1;
    end
  endtask

  initial begin
    seed = 32'hc95f;
    aresetn <= 1'b0; awv <= 1'b0; wv <= 1'b0; br <= 1'b0; arv <= 1'b0; rr <= 1'b0;
    awa <= 8'h00; ara <= 8'h00; wd <= 32'h0; done <= 1'b0; cyc <= 0; trg <= 16'h0000;
    pend_m = 16'h0000; busy_open = 1'b0; hit = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(A_PRI); `CHK(d, 32'h00000200)
    rdr(A_FRC); `CHK(d, 32'h00000000)
    rdr(8'h40); `CHK(r, csa_pkg::RESP_SLVERR)
    `CHK(d, 32'h00000000)
    wr(8'h40, 32'hFFFF); `CHK(r, csa_pkg::RESP_SLVERR)
    // Cutoff never above the all-fixed code
    for (int c = 0; c <= 16; c++) begin
      for (int k = 0; k < 2; k++) begin
        if (k == 0) begin
          wr(A_PRI, 32'(c));
          cut_m = c;
          ptr_m = 16;
          if (busy_open) `CHK(busy, 1'b1)
        end
        m = 16'($random(seed));
        if (m == 16'h0000) m = 16'h0001;
        wr(A_FRC, {16'h0000, m}); `CHK(r, csa_pkg::RESP_OKAY)
        pend_m = pend_m | m;
        drain;
        rdr(A_PRI); `CHK(d, 32'((ptr_m << 5) | cut_m))
        `CHK(d[9:5] <= 5'h10, 1'b1)
        rdr(A_PND); `CHK(d, 32'h00000000)
        rdr(A_FRC); `CHK(d, 32'h00000000)
      end
    end
    wr(8'h00, 32'h1);
    busy_open = 1'b0; pend_m = 16'h0000; cut_m = 0; ptr_m = 16;
    rdr(A_PRI); `CHK(d, 32'h00000200)
    wr(A_FRC, 32'h8001);
    pend_m = 16'h8001;
    drain;
    rdr(A_PRI); `CHK(d, 32'h000001E0)
    // Repeat force and a trigger while busy; only the trigger marks overrun
    wr(A_FRC, 32'h0020);
    wr(A_FRC, 32'h0020);
    @(posedge aclk) trg <= 16'h0060;
    @(posedge aclk) trg <= 16'h0000;
    pend_m = 16'h0060;
    rdr(A_OVF); `CHK(d, 32'h00000020)
    // Done lands so that slot 5 is granted in the cycle its force executes
    hit = 1'b1;
    wr(A_FRC, 32'h0020);
    hit = 1'b0;
    `CHK(slot, 4'h5)
    ptr_m = 5;
    rdr(A_PND); `CHK(d, 32'h00000060)
    rdr(A_OVF); `CHK(d, 32'h00000020)
    drain;
    rdr(A_PRI); `CHK(d, 32'((ptr_m << 5) | cut_m))
    close_out;
  end
endmodule
